// ==== rtcrb_params.svh ====
// Purpose: Constants for the real-time channel register bank.
// Assumes: Included by bare name; defines only.
// Notes: Host byte offsets equal DSP word addresses minus the bank base.
`ifndef RTCRB_PARAMS_SVH
`define RTCRB_PARAMS_SVH

// ****************************************************************
// Address map
// ****************************************************************
`define RTCRB_DSP_BANK_HI 8'h30
`define RTCRB_AREA_SIZE 7'h40
`define RTCRB_SLOT_COUNT 3'h6
`define RTCRB_SLOT_AUDIO_ONE 3'h0
`define RTCRB_SLOT_AUDIO_TWO 3'h1
`define RTCRB_SLOT_HDLC_ONE_RX 3'h2
`define RTCRB_SLOT_HDLC_ONE_TX 3'h3
`define RTCRB_SLOT_HDLC_TWO_RX 3'h4
`define RTCRB_SLOT_HDLC_TWO_TX 3'h5

// ****************************************************************
// Unit sizes and reset values
// ****************************************************************
`define RTCRB_UNIT_ONE_BYTE 5'h07
`define RTCRB_UNIT_TWO_BYTES 5'h0f
`define RTCRB_UNIT_FOUR_BYTES 5'h1f
`define RTCRB_WORD_RESET 32'h0000_0000

`endif

// ==== rtcrb_pkg.sv ====
// Purpose: Types shared by the real-time channel register bank.
// Assumes: Constants live in rtcrb_params.svh.
// Notes: Enum codes follow declaration order.
package rtcrb_pkg;

   // Bank area selected by the two top bits of a bank offset.
   typedef enum logic [1:0] {
      RTCRB_AREA_CHAN,
      RTCRB_AREA_COM,
      RTCRB_AREA_HDLC_ONE,
      RTCRB_AREA_HDLC_TWO
   } rtcrb_area_t;

   // Frame sync that marks a physical frame start for one channel.
   typedef enum logic [1:0] {
      RTCRB_SYNC_TDM,
      RTCRB_SYNC_AUDIO_RX,
      RTCRB_SYNC_AUDIO_TX,
      RTCRB_SYNC_OFF
   } rtcrb_sync_sel_t;

endpackage

// ==== rtcrb_sync2.sv ====
// Purpose: Two-stage synchroniser for asynchronous levels.
// Assumes: Inputs are pins from outside the clk domain.
// Notes: Only the second stage may be read by other logic.
`timescale 1ns/100ps
`default_nettype none
module rtcrb_sync2 #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_r <= '0;
         sync_out <= '0;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule
`default_nettype wire

// ==== rtcrb_lane.sv ====
// Purpose: One serial channel lane: receive capture and transmit drive.
// Assumes: bit_en and frame_start are one-cycle pulses on clk.
// Notes: A bit strobe in the frame-start cycle is captured into the finishing unit in frame mode.
`include "rtcrb_params.svh"
`timescale 1ns/100ps
`default_nettype none
module rtcrb_lane (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Configuration
   input wire logic [4:0] unit_m1,
   input wire logic lsb_first,
   input wire logic frame_mode,
   // Serial side
   input wire logic frame_start,
   input wire logic bit_en,
   input wire logic bit_in,
   output logic bit_out,
   // Word side
   input wire logic [31:0] tx_word,
   output logic [31:0] cap_word,
   output logic unit_done
);

   logic [31:0] rx_sh_r;
   logic [31:0] rx_sh_nxt;
   logic [31:0] tx_sh_r;
   logic [4:0] cnt_r;
   logic [4:0] pos;
   logic full_r;
   logic take;
   logic last;
   logic done_nxt;

   // Position of the current bit: MSB-first fills from unit_m1 down, so
   // short units end up justified at bit 0 either way.
   always_comb begin
      take = bit_en && !full_r;
      last = (cnt_r >= unit_m1);
      pos = lsb_first ? cnt_r : 5'(unit_m1 - cnt_r);
      rx_sh_nxt = rx_sh_r;
      if (take) begin
         rx_sh_nxt[pos] = bit_in;
      end
      if (frame_mode) begin
         done_nxt = frame_start;
      end else begin
         done_nxt = take && last;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_sh_r <= `RTCRB_WORD_RESET;
         tx_sh_r <= `RTCRB_WORD_RESET;
         cap_word <= `RTCRB_WORD_RESET;
         cnt_r <= 5'h0_0;
         full_r <= 1'b0;
         unit_done <= 1'b0;
      end else begin
         unit_done <= done_nxt;
         if (done_nxt) begin
            // Second buffer stage: the finished unit moves out while the
            // shifters restart, so software has a whole unit to respond.
            cap_word <= rx_sh_nxt;
            tx_sh_r <= tx_word;
            rx_sh_r <= `RTCRB_WORD_RESET;
            cnt_r <= 5'h0_0;
            full_r <= 1'b0;
         end else if (take) begin
            rx_sh_r <= rx_sh_nxt;
            if (last) begin
               full_r <= 1'b1;
            end else begin
               cnt_r <= 5'(cnt_r + 5'h0_1);
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bit_out <= 1'b0;
      end else if (take) begin
         bit_out <= tx_sh_r[pos];
      end
   end

endmodule
`default_nettype wire

// ==== rtcrb_bank.sv ====
// Purpose: Real-time channel register bank shared by host and DSP.
// Assumes: Bus strobes and serial lane strobes are synchronous to clk.
// Notes: Frame sync pins are asynchronous and are synchronised here.
`include "rtcrb_params.svh"
`timescale 1ns/100ps
`default_nettype none
module rtcrb_bank (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Host byte bus
   input wire logic [7:0] host_addr,
   input wire logic [7:0] host_wdata,
   input wire logic host_wr,
   input wire logic host_rd,
   output logic [7:0] host_rdata,
   // DSP word bus
   input wire logic [15:0] dsp_addr,
   input wire logic [15:0] dsp_wdata,
   input wire logic dsp_wr,
   input wire logic dsp_rd,
   output logic [15:0] dsp_rdata,
   // HDLC register areas on the host side
   input wire logic hdlc_one_host_access_enable,
   input wire logic hdlc_two_host_access_enable,
   output logic [1:0] hdlc_host_wr,
   output logic [1:0] hdlc_host_rd,
   output logic [5:0] hdlc_host_offset,
   input wire logic [7:0] hdlc_one_host_rdata,
   input wire logic [7:0] hdlc_two_host_rdata,
   // Frame sync pins
   input wire logic tdm_frame_sync,
   input wire logic audio_receive_frame_sync,
   input wire logic audio_transmit_frame_sync,
   // Channel configuration
   input wire logic [4:0] audio_one_unit_m1,
   input wire logic [4:0] audio_two_unit_m1,
   input wire logic [1:0] hdlc_one_unit_sel,
   input wire logic [1:0] hdlc_two_unit_sel,
   input wire logic [1:0] receive_bit_order_select,
   input wire logic [1:0] transmit_bit_order_select,
   input wire logic [5:0] lane_frame_mode,
   input wire rtcrb_pkg::rtcrb_sync_sel_t [5:0] lane_sync_sel,
   input wire logic [5:0] lane_tx_src_dsp,
   // Serial lanes
   input wire logic [5:0] lane_bit_en,
   input wire logic [5:0] lane_bit_in,
   output logic [5:0] lane_bit_out,
   // Channel status and interrupts
   input wire logic [5:0] chan_status_clear,
   input wire logic [5:0] host_irq_mask,
   input wire logic [5:0] dsp_irq_mask,
   output logic [5:0] chan_status,
   output logic host_high_priority_irq,
   output logic dsp_high_priority_irq
);
   import rtcrb_pkg::*;

   // ****************************************************************
   // Frame sync edges
   // ****************************************************************
   logic [2:0] fs_sync;
   logic [2:0] fs_prev_r;
   logic [2:0] fs_rise;

   rtcrb_sync2 #(
      .WIDTH(3)
   ) u_fs_sync (
      .clk(clk),
      .rstn(rstn),
      .async_in({audio_transmit_frame_sync, audio_receive_frame_sync, tdm_frame_sync}),
      .sync_out(fs_sync)
   );

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fs_prev_r <= 3'h0;
      end else begin
         fs_prev_r <= fs_sync;
      end
   end

   assign fs_rise = fs_sync & ~fs_prev_r;

   // ****************************************************************
   // Lane configuration
   // ****************************************************************
   function automatic logic [4:0] hdlc_unit(input logic [1:0] sel);
      case (sel)
         2'h0: hdlc_unit = `RTCRB_UNIT_ONE_BYTE;
         2'h1: hdlc_unit = `RTCRB_UNIT_TWO_BYTES;
         default: hdlc_unit = `RTCRB_UNIT_FOUR_BYTES;
      endcase
   endfunction

   logic [4:0] lane_unit_m1 [6];
   logic [5:0] lane_lsb_first;
   logic [5:0] lane_frame_start;

   always_comb begin
      lane_unit_m1[`RTCRB_SLOT_AUDIO_ONE] = audio_one_unit_m1;
      lane_unit_m1[`RTCRB_SLOT_AUDIO_TWO] = audio_two_unit_m1;
      lane_unit_m1[`RTCRB_SLOT_HDLC_ONE_RX] = hdlc_unit(hdlc_one_unit_sel);
      lane_unit_m1[`RTCRB_SLOT_HDLC_ONE_TX] = hdlc_unit(hdlc_one_unit_sel);
      lane_unit_m1[`RTCRB_SLOT_HDLC_TWO_RX] = hdlc_unit(hdlc_two_unit_sel);
      lane_unit_m1[`RTCRB_SLOT_HDLC_TWO_TX] = hdlc_unit(hdlc_two_unit_sel);
      // A select bit of 1 means MSB first; audio is always MSB first.
      lane_lsb_first = {~transmit_bit_order_select[1], ~receive_bit_order_select[1],
                        ~transmit_bit_order_select[0], ~receive_bit_order_select[0],
                        2'b00};
      for (int i = 0; i < 6; i++) begin
         case (lane_sync_sel[i])
            RTCRB_SYNC_TDM: lane_frame_start[i] = fs_rise[0];
            RTCRB_SYNC_AUDIO_RX: lane_frame_start[i] = fs_rise[1];
            RTCRB_SYNC_AUDIO_TX: lane_frame_start[i] = fs_rise[2];
            default: lane_frame_start[i] = 1'b0;
         endcase
      end
   end

   // ****************************************************************
   // Channel lanes
   // ****************************************************************
   logic [31:0] host_tx_r [6];
   logic [31:0] dsp_tx_r [6];
   logic [31:0] host_rx_r [6];
   logic [31:0] dsp_rx_r [6];
   logic [31:0] lane_cap [6];
   logic [5:0] lane_done;

   // Lanes 0/1 are the audio channels, 2..5 the HDLC rx and tx access
   // channels; each lane captures into a readback and drives a written word.
   for (genvar g = 0; g < 6; g++) begin : g_lane
      rtcrb_lane u_lane (
         .clk(clk),
         .rstn(rstn),
         .unit_m1(lane_unit_m1[g]),
         .lsb_first(lane_lsb_first[g]),
         .frame_mode(lane_frame_mode[g]),
         .frame_start(lane_frame_start[g]),
         .bit_en(lane_bit_en[g]),
         .bit_in(lane_bit_in[g]),
         .bit_out(lane_bit_out[g]),
         .tx_word(lane_tx_src_dsp[g] ? dsp_tx_r[g] : host_tx_r[g]),
         .cap_word(lane_cap[g]),
         .unit_done(lane_done[g])
      );
   end

   // ****************************************************************
   // Address decode
   // ****************************************************************
   rtcrb_area_t host_area;
   rtcrb_area_t dsp_area;
   logic [2:0] host_slot;
   logic [2:0] dsp_slot;
   logic host_slot_ok;
   logic dsp_slot_ok;
   logic dsp_in_bank;
   logic [1:0] hdlc_host_ok;

   always_comb begin
      host_area = rtcrb_area_t'(host_addr[7:6]);
      host_slot = host_addr[4:2];
      host_slot_ok = (host_area == RTCRB_AREA_CHAN) && !host_addr[5] &&
                     (host_slot < `RTCRB_SLOT_COUNT);
      dsp_in_bank = (dsp_addr[15:8] == `RTCRB_DSP_BANK_HI);
      dsp_area = rtcrb_area_t'(dsp_addr[7:6]);
      dsp_slot = dsp_addr[4:2];
      dsp_slot_ok = dsp_in_bank && (dsp_area == RTCRB_AREA_CHAN) && !dsp_addr[5] &&
                    (dsp_slot < `RTCRB_SLOT_COUNT);
      hdlc_host_ok[0] = (host_area == RTCRB_AREA_HDLC_ONE) && hdlc_one_host_access_enable;
      hdlc_host_ok[1] = (host_area == RTCRB_AREA_HDLC_TWO) && hdlc_two_host_access_enable;
   end

   // Disabled HDLC areas see no strobe, so host writes there are dropped.
   assign hdlc_host_wr = hdlc_host_ok & {2{host_wr}};
   assign hdlc_host_rd = hdlc_host_ok & {2{host_rd}};
   assign hdlc_host_offset = host_addr[5:0];

   // ****************************************************************
   // Write registers (host and DSP copies kept apart)
   // ****************************************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 6; i++) begin
            host_tx_r[i] <= `RTCRB_WORD_RESET;
         end
      end else if (host_wr && host_slot_ok) begin
         host_tx_r[host_slot][8*host_addr[1:0] +: 8] <= host_wdata;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 6; i++) begin
            dsp_tx_r[i] <= `RTCRB_WORD_RESET;
         end
      end else if (dsp_wr && dsp_slot_ok) begin
         dsp_tx_r[dsp_slot][16*dsp_addr[1] +: 16] <= dsp_wdata;
      end
   end

   // ****************************************************************
   // Read registers (loaded at each unit end)
   // ****************************************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 6; i++) begin
            host_rx_r[i] <= `RTCRB_WORD_RESET;
            dsp_rx_r[i] <= `RTCRB_WORD_RESET;
         end
      end else begin
         for (int i = 0; i < 6; i++) begin
            if (lane_done[i]) begin
               host_rx_r[i] <= lane_cap[i];
               dsp_rx_r[i] <= lane_cap[i];
            end
         end
      end
   end

   // ****************************************************************
   // Read data
   // ****************************************************************
   logic [7:0] host_rd_byte;

   always_comb begin
      host_rd_byte = 8'h00;
      if (host_slot_ok) begin
         host_rd_byte = host_rx_r[host_slot][8*host_addr[1:0] +: 8];
      end else if (hdlc_host_ok[0]) begin
         host_rd_byte = hdlc_one_host_rdata;
      end else if (hdlc_host_ok[1]) begin
         host_rd_byte = hdlc_two_host_rdata;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         host_rdata <= 8'h00;
      end else if (host_rd) begin
         host_rdata <= host_rd_byte;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dsp_rdata <= 16'h0000;
      end else if (dsp_rd) begin
         // Only the channel area answers on this port; the rest reads zero.
         dsp_rdata <= dsp_slot_ok ? dsp_rx_r[dsp_slot][16*dsp_addr[1] +: 16] : 16'h0000;
      end
   end

   // ****************************************************************
   // Channel status and interrupt lines
   // ****************************************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         chan_status <= 6'h00;
      end else begin
         // A unit end in the clear cycle is kept: set wins over clear.
         chan_status <= (chan_status & ~chan_status_clear) | lane_done;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         host_high_priority_irq <= 1'b0;
         dsp_high_priority_irq <= 1'b0;
      end else begin
         host_high_priority_irq <= |(chan_status & host_irq_mask);
         dsp_high_priority_irq <= |(chan_status & dsp_irq_mask);
      end
   end

endmodule
`default_nettype wire

// ==== rtcrb_hdlc_model.sv ====
// Purpose: Behavioural model of the two HDLC controller register areas.
// Assumes: Strobes arrive from the bank already gated by the access enables.
// Notes: A released read bus shows the inverse of the last byte, never a stale copy.
`timescale 1ns/100ps
`default_nettype none
module rtcrb_hdlc_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Host side of the HDLC areas
   input wire logic [1:0] hdlc_host_wr,
   input wire logic [1:0] hdlc_host_rd,
   input wire logic [5:0] hdlc_host_offset,
   input wire logic [7:0] host_wdata,
   output logic [7:0] hdlc_one_host_rdata,
   output logic [7:0] hdlc_two_host_rdata
);
   logic [7:0] mem_r [2][64];
   logic [7:0] last_r [2];
   // ****************************************
   // Storage
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      for (int a = 0; a < 2; a++) begin
         for (int i = 0; i < 64; i++) begin
            if (!rstn) begin
               mem_r[a][i] <= 8'(i) ^ (a == 1 ? 8'ha5 : 8'h5a);
            end else if (hdlc_host_wr[a] && hdlc_host_offset == 6'(i)) begin
               mem_r[a][i] <= host_wdata;
            end
         end
         if (!rstn) begin
            last_r[a] <= 8'h00;
         end else if (hdlc_host_rd[a]) begin
            last_r[a] <= mem_r[a][hdlc_host_offset];
         end
      end
   end
   // Outside a read the bus carries the complement so a late sample cannot pass.
   assign hdlc_one_host_rdata = hdlc_host_rd[0] ? mem_r[0][hdlc_host_offset] : ~last_r[0];
   assign hdlc_two_host_rdata = hdlc_host_rd[1] ? mem_r[1][hdlc_host_offset] : ~last_r[1];
endmodule
`default_nettype wire

// ==== rtcrb_props.sv ====
// Purpose: Concurrent checks on the ports of the channel register bank.
// Assumes: Bound to every rtcrb_bank instance.
// Notes: The combinational HDLC strobes are judged at the clock edge only.
`timescale 1ns/100ps
`default_nettype none
module rtcrb_props (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Host and DSP buses
   input wire logic [7:0] host_addr,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [7:0] host_rdata,
   input wire logic [15:0] dsp_addr,
   input wire logic dsp_rd,
   input wire logic [15:0] dsp_rdata,
   // HDLC areas
   input wire logic hdlc_one_host_access_enable,
   input wire logic hdlc_two_host_access_enable,
   input wire logic [1:0] hdlc_host_wr,
   input wire logic [1:0] hdlc_host_rd,
   input wire logic [7:0] hdlc_one_host_rdata,
   // Status and interrupts
   input wire logic [5:0] chan_status_clear,
   input wire logic [5:0] host_irq_mask,
   input wire logic [5:0] dsp_irq_mask,
   input wire logic [5:0] chan_status,
   input wire logic host_high_priority_irq,
   input wire logic dsp_high_priority_irq
);
   wire logic sel_one = host_addr[7:6] == 2'b10 && hdlc_one_host_access_enable;
   wire logic sel_two = host_addr[7:6] == 2'b11 && hdlc_two_host_access_enable;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ****************************************
   // Properties
   // ****************************************
   a_hdlc_wr_gate: assert property (hdlc_host_wr == {host_wr && sel_two, host_wr && sel_one})
      else $error("HDLC write strobe not gated by area and enable");
   a_hdlc_rd_gate: assert property (hdlc_host_rd == {host_rd && sel_two, host_rd && sel_one})
      else $error("HDLC read strobe not gated by area and enable");
   a_hdlc_rd_pass: assert property (host_rd && sel_one |=> host_rdata == $past(hdlc_one_host_rdata))
      else $error("HDLC area one read byte not returned");
   a_com_read_zero: assert property (host_rd && host_addr[7:6] == 2'b01 |=> host_rdata == 8'h00)
      else $error("Unimplemented area read not zero");
   a_chan_gap_zero: assert property (host_rd && host_addr[7:6] == 2'b00 && host_addr[5:0] >= 6'h18
      |=> host_rdata == 8'h00)
      else $error("Unused channel location read not zero");
   a_dsp_gap_zero: assert property (dsp_rd && dsp_addr[15:8] == 8'h30 && dsp_addr[7:0] >= 8'h18
      |=> dsp_rdata == 16'h0000)
      else $error("Unused DSP location read not zero");
   a_rdata_hold: assert property (!host_rd |=> $stable(host_rdata))
      else $error("Host read byte changed without a read");
   a_status_sticky: assert property ((chan_status & ~chan_status_clear) != 6'h00
      |=> (($past(chan_status) & ~$past(chan_status_clear)) & ~chan_status) == 6'h00)
      else $error("Channel status dropped without a clear");
   a_host_irq_map: assert property (host_high_priority_irq == |($past(chan_status) & $past(host_irq_mask)))
      else $error("Host interrupt does not follow masked status");
   a_dsp_irq_map: assert property (dsp_high_priority_irq == |($past(chan_status) & $past(dsp_irq_mask)))
      else $error("DSP interrupt does not follow masked status");
endmodule
bind rtcrb_bank rtcrb_props u_props (.clk, .rstn, .host_addr, .host_wr, .host_rd, .host_rdata,
   .dsp_addr, .dsp_rd, .dsp_rdata, .hdlc_one_host_access_enable, .hdlc_two_host_access_enable,
   .hdlc_host_wr, .hdlc_host_rd, .hdlc_one_host_rdata, .chan_status_clear, .host_irq_mask,
   .dsp_irq_mask, .chan_status, .host_high_priority_irq, .dsp_high_priority_irq);
`default_nettype wire

// ==== rtcrb_bank_tb.sv ====
// Purpose: Self-checking bench for the channel register bank.
// Assumes: Inputs change on the falling clock edge only.
// Notes: Random samples come from a fixed seed so runs repeat.
`timescale 1ns/100ps
`default_nettype none
module rtcrb_bank_tb;
   import rtcrb_pkg::*;
   logic clk = 1'b0;
   logic rstn, host_wr, host_rd, dsp_wr, dsp_rd, en1, en2, h_irq, d_irq, fs_tdm, fs_rx, fs_tx;
   logic [7:0] host_addr, host_wdata, host_rdata, h1_rd, h2_rd, b;
   logic [15:0] dsp_addr, dsp_wdata, dsp_rdata;
   logic [1:0] hw_s, hr_s, u1, u2, rbo, tbo;
   logic [5:0] hoff, fmode, src_dsp, bit_en, bit_in, bit_out, st_clr, hmask, dmask, status;
   logic [4:0] a1m, a2m;
   logic [31:0] v, pend, cur;
   rtcrb_sync_sel_t [5:0] ssel;
   int n_errors = 0;
   int samples_checked = 0;
   int seed = 43254;
   int n;
   always #2 clk = ~clk;
   rtcrb_bank dut (.clk(clk), .rstn(rstn), .host_addr(host_addr), .host_wdata(host_wdata),
      .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata), .dsp_addr(dsp_addr),
      .dsp_wdata(dsp_wdata), .dsp_wr(dsp_wr), .dsp_rd(dsp_rd), .dsp_rdata(dsp_rdata),
      .hdlc_one_host_access_enable(en1), .hdlc_two_host_access_enable(en2), .hdlc_host_wr(hw_s),
      .hdlc_host_rd(hr_s), .hdlc_host_offset(hoff), .hdlc_one_host_rdata(h1_rd),
      .hdlc_two_host_rdata(h2_rd), .tdm_frame_sync(fs_tdm), .audio_receive_frame_sync(fs_rx),
      .audio_transmit_frame_sync(fs_tx), .audio_one_unit_m1(a1m), .audio_two_unit_m1(a2m),
      .hdlc_one_unit_sel(u1), .hdlc_two_unit_sel(u2), .receive_bit_order_select(rbo),
      .transmit_bit_order_select(tbo), .lane_frame_mode(fmode), .lane_sync_sel(ssel),
      .lane_tx_src_dsp(src_dsp), .lane_bit_en(bit_en), .lane_bit_in(bit_in), .lane_bit_out(bit_out),
      .chan_status_clear(st_clr), .host_irq_mask(hmask), .dsp_irq_mask(dmask), .chan_status(status),
      .host_high_priority_irq(h_irq), .dsp_high_priority_irq(d_irq));
   rtcrb_hdlc_model u_hdlc (.clk(clk), .rstn(rstn), .hdlc_host_wr(hw_s), .hdlc_host_rd(hr_s),
      .hdlc_host_offset(hoff), .host_wdata(host_wdata), .hdlc_one_host_rdata(h1_rd),
      .hdlc_two_host_rdata(h2_rd));
   // ****************************************
   // Expectation helpers
   // ****************************************
   function automatic logic bit_at(input logic [31:0] w, input int len, input int k, input logic msb);
      return msb ? w[len - 1 - k] : w[k];
   endfunction
   function automatic logic [31:0] trim(input logic [31:0] w, input int len);
      return w & ((32'h0000_0001 << len) - 32'h0000_0001);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // ****************************************
   // Bus cycles
   // ****************************************
   task automatic hbus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      host_addr = a;
      host_wdata = d;
      {host_wr, host_rd} = {wr, !wr};
      @(negedge clk);
      {host_wr, host_rd} = 2'b00;
      b = host_rdata;
   endtask
   task automatic dbus(input logic wr, input logic [15:0] a, input logic [15:0] d);
      @(negedge clk);
      dsp_addr = a;
      dsp_wdata = d;
      {dsp_wr, dsp_rd} = {wr, !wr};
      @(negedge clk);
      {dsp_wr, dsp_rd} = 2'b00;
   endtask
   // Host moves a sample as four ascending bytes, the DSP as two ascending words.
   task automatic hword(input logic wr, input int slot, input logic [31:0] w);
      for (int i = 0; i < 4; i++) begin
         hbus(wr, 8'(4 * slot + i), w[8 * i +: 8]);
         v[8 * i +: 8] = b;
      end
   endtask
   task automatic dword(input logic wr, input int slot, input logic [31:0] w);
      for (int i = 0; i < 2; i++) begin
         dbus(wr, 16'h3000 + 16'(4 * slot + 2 * i), w[16 * i +: 16]);
         v[16 * i +: 16] = dsp_rdata;
      end
   endtask
   task automatic unit_run(input int ln, input int len, input logic msb, input logic rd,
      input logic ctx, input logic [31:0] tx);
      logic [31:0] rx;
      rx = $random(seed);
      for (int k = 0; k < len; k++) begin
         @(negedge clk);
         bit_en[ln] = 1'b1;
         bit_in[ln] = bit_at(rx, len, k, msb);
         @(negedge clk);
         bit_en[ln] = 1'b0;
         if (ctx) chk(bit_out[ln], bit_at(tx, len, k, msb), "tx bit");
      end
      repeat (4) @(negedge clk);
      if (rd) begin
         chk(status[ln], 1'b1, "status");
         chk(h_irq, hmask[ln], "host irq");
         chk(d_irq, dmask[ln], "dsp irq");
         hword(1'b0, ln, 32'h0);
         chk(v, trim(rx, len), "host rx");
         dword(1'b0, ln, 32'h0);
         chk(v, trim(rx, len), "dsp rx");
      end
      st_clr = 6'h3f;
      @(negedge clk);
      st_clr = 6'h00;
   endtask
   task automatic final_report;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      final_report;
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {rstn, host_wr, host_rd, dsp_wr, dsp_rd, en1, en2, fs_tdm, fs_rx, fs_tx} = '0;
      {host_addr, host_wdata, dsp_addr, dsp_wdata, u1, u2, rbo, tbo, a1m, a2m} = '0;
      {fmode, src_dsp, bit_en, bit_in, st_clr} = '0;
      hmask = 6'h15;
      dmask = 6'h2a;
      ssel = '{default: RTCRB_SYNC_OFF};
      repeat (5) @(negedge clk);
      rstn = 1'b1;
      pend = 32'ha5a5_5a5a;
      hword(1'b1, 0, pend);
      hword(1'b0, 0, 32'h0);
      chk(v, 32'h0, "rx apart from tx");
      hbus(1'b0, 8'h20, 8'h00);
      chk(b, 8'h00, "gap read");
      hbus(1'b0, 8'h40, 8'h00);
      chk(b, 8'h00, "com read");
      dbus(1'b0, 16'h3040, 16'h0);
      chk(dsp_rdata, 16'h0, "dsp gap read");
      cur = 32'h0;
      for (int i = 0; i < 6; i++) begin
         n = (i == 0) ? 1 : (i == 1) ? 32 : 1 + int'($unsigned($random(seed)) % 32);
         a1m = 5'(n - 1);
         unit_run(0, n, 1'b1, 1'b1, 1'b1, cur);
         cur = pend;
         pend = $random(seed);
         hword(1'b1, 0, pend);
      end
      src_dsp[1] = 1'b1;
      a2m = 5'd15;
      cur = 32'h0;
      pend = $random(seed);
      dword(1'b1, 1, pend);
      for (int i = 0; i < 2; i++) begin
         unit_run(1, 16, 1'b1, 1'b1, 1'b1, cur);
         cur = pend;
      end
      for (int a = 0; a < 2; a++) begin
         for (int s = 0; s < 8; s++) begin
            {u2, u1} = {2{2'(s >> 1)}};
            rbo[a] = s[0];
            unit_run(2 + 2 * a, (s >> 1) == 3 ? 32 : 8 << (s >> 1), s[0], 1'b1, 1'b0, 32'h0);
         end
         {u2, u1} = 4'b0101;
         cur = 32'h0;
         for (int o = 0; o < 2; o++) begin
            tbo[a] = o[0];
            pend = $random(seed);
            hword(1'b1, 3 + 2 * a, pend);
            unit_run(3 + 2 * a, 16, o[0], 1'b0, 1'b1, cur);
            cur = pend;
         end
      end
      for (int a = 0; a < 2; a++) begin
         {en2, en1} = 2'b00;
         hbus(1'b1, 8'h85 + 8'(64 * a), 8'h3c);
         hbus(1'b0, 8'h85 + 8'(64 * a), 8'h00);
         chk(b, 8'h00, "disabled area read");
         {en2, en1} = 2'(1 << a);
         hbus(1'b0, 8'h85 + 8'(64 * a), 8'h00);
         chk(b, 8'h05 ^ (a == 1 ? 8'ha5 : 8'h5a), "area read");
         hbus(1'b1, 8'h85 + 8'(64 * a), 8'hc3);
         hbus(1'b0, 8'h85 + 8'(64 * a), 8'h00);
         chk(b, 8'hc3, "area write");
      end
      fmode = 6'h07;
      for (int i = 0; i < 3; i++) begin
         ssel[i] = rtcrb_sync_sel_t'(i);
         repeat (6) @(negedge clk);
         chk(status[i], 1'b0, "no frame yet");
         {fs_tx, fs_rx, fs_tdm} = 3'(1 << i);
         n = 0;
         while (status[i] !== 1'b1 && n < 12) begin
            @(negedge clk);
            n++;
         end
         chk(status[i], 1'b1, "frame status");
         {fs_tx, fs_rx, fs_tdm} = 3'b000;
         repeat (4) @(negedge clk);
         st_clr = 6'h3f;
         @(negedge clk);
         st_clr = 6'h00;
      end
      final_report;
   end
endmodule
`default_nettype wire
